/* logic/pbps_pkg.sv */
// What this block does
// - pad B5 field bits 15:14: 00 timer ch1, 01 fault_input_three, 10 SPI clock, 11 reserved
// - pad B4 field bits 13:11: timer ch0, clock out, MISO, SDA, SERIAL_COMM_INTERFACE rx, analog 0
// - pad B3 field bits 10:8: MOSI, timer in3, analog 3, pulse out5, comparator1
// - pad B2 field bits 7:6: MISO, timer in2, analog 2, comparator0 result
// - bit 5 reserved; pad B1 bits 4:3: slave select, SDA, analog 12, 11 reserved
// - pad B0 bits 2:0: 001 SCL, 010 analog, 011 pulse out3, 100 timer ch1
// - pad B0 code 000 feeds SPI clock as input only; B5 carries it both ways
// - upper register bits 15:4 reserved; pad B7 bits 3:2: SERIAL_COMM_INTERFACE tx, SCL, analog
// - pad B6 bits 1:0: SERIAL_COMM_INTERFACE rx, SDA, analog, external clock input
// - upper port B select at offset 0x0D, port C select at 0x0E
// - peripheral enable 0 gives pad to GPIO; 1 lets the select field choose
// - several pads on one function: output fans out, input is OR or AND
// - function on no pad: output reaches nothing, input held at a constant
package pbps_pkg;

  // register offsets
  localparam logic [7:0] REG_SEL_B_LO = 8'h0C;
  localparam logic [7:0] REG_SEL_B_HI = 8'h0D;
  localparam logic [7:0] REG_SEL_C = 8'h0E;

  // writable bits and reset values
  localparam logic [15:0] MASK_B_LO = 16'hFFDF;
  localparam logic [15:0] MASK_B_HI = 16'h000F;
  localparam logic [15:0] MASK_C = 16'h0003;
  localparam logic [15:0] RESET_SEL = 16'h0000;

  // field positions
  localparam int B5_LSB = 14;
  localparam int B4_LSB = 11;
  localparam int B3_LSB = 8;
  localparam int B2_LSB = 6;
  localparam int B1_LSB = 3;
  localparam int B0_LSB = 0;
  localparam int B7_LSB = 2;
  localparam int B6_LSB = 0;

  // idle levels of peripheral inputs when no pad feeds them
  localparam logic IDLE_LOW = 1'b0;
  localparam logic IDLE_HIGH = 1'b1;

  // signals coming from the peripherals toward the pads
  typedef struct packed {
    logic timer0Out;
    logic timer0Drive;
    logic timer1Out;
    logic timer1Drive;
    logic spiClkOut;
    logic spiClkDrive;
    logic spiMisoOut;
    logic spiMisoDrive;
    logic spiMosiOut;
    logic spiMosiDrive;
    logic spiSlaveSelectOut;
    logic spiSlaveSelectDrive;
    logic i2cSdaOut;
    logic i2cSdaDrive;
    logic i2cSclOut;
    logic i2cSclDrive;
    logic sciTxOut;
    logic sciTxDrive;
    logic clockOutputZero;
    logic pulseOutputThree;
    logic pulseOutputFive;
    logic comparatorZeroResult;
    logic comparatorOneResult;
  } pbps_periph_out_t;

  // signals going from the pads into the peripherals
  typedef struct packed {
    logic timer0In;
    logic timer1In;
    logic faultInputThree;
    logic spiClkIn;
    logic spiMisoIn;
    logic spiMosiIn;
    logic spiSlaveSelectIn;
    logic i2cSdaIn;
    logic i2cSclIn;
    logic sciRxIn;
    logic sciTxIn;
    logic timerInputTwo;
    logic timerInputThree;
    logic externalClockInput;
  } pbps_periph_in_t;

endpackage : pbps_pkg

/* logic/pbps_pin_mux.sv */
// Chosen here: the plain strobed port.
module pbps_pin_mux (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [15:0] rdData,
  // peripheral enable bits from the GPIO, one per pad
  input wire logic [7:0] padPeripheralEnable,
  // GPIO side of each pad
  input wire logic [7:0] gpioOut,
  input wire logic [7:0] gpioOeN,
  output logic [7:0] gpioIn,
  // pads
  input wire logic [7:0] padIn,
  output logic [7:0] padOut,
  output logic [7:0] padOeN,
  output logic [7:0] padAnalogSel,
  // peripherals
  input wire pbps_pkg::pbps_periph_out_t periphOut,
  output pbps_pkg::pbps_periph_in_t periphIn,
  // port C field bits for the port C mux
  output logic [1:0] portCSelect
);

  logic [15:0] selLo;
  logic [15:0] selHi;
  logic [15:0] selC;
  logic [15:0] next_selLo;
  logic [15:0] next_selHi;
  logic [15:0] next_selC;
  logic [15:0] next_rdData;
  logic [1:0] b5;
  logic [2:0] b4;
  logic [2:0] b3;
  logic [1:0] b2;
  logic [1:0] b1;
  logic [2:0] b0;
  logic [1:0] b7;
  logic [1:0] b6;
  logic [7:0] mT0;
  logic [7:0] mT1;
  logic [7:0] mFault3;
  logic [7:0] mSclk;
  logic [7:0] mMiso;
  logic [7:0] mMosi;
  logic [7:0] mSs;
  logic [7:0] mSda;
  logic [7:0] mScl;
  logic [7:0] mRx;
  logic [7:0] mTx;
  logic [7:0] mTin2;
  logic [7:0] mTin3;
  logic [7:0] mClkIn;

  // wired OR for idle-low inputs, wired AND for idle-high; no pad gives idle
  function automatic logic joinIn(input logic [7:0] mask, input logic [7:0] pads,
                                  input logic idle);
    joinIn = idle ? &(pads | ~mask) : |(pads & mask);
  endfunction : joinIn

  // register writes and read data
  always_comb begin
    next_selLo = selLo;
    next_selHi = selHi;
    next_selC = selC;
    next_rdData = 16'h0000;
    if (wrEn) begin
      unique case (addr)
        pbps_pkg::REG_SEL_B_LO: next_selLo = wrData & pbps_pkg::MASK_B_LO;
        pbps_pkg::REG_SEL_B_HI: next_selHi = wrData & pbps_pkg::MASK_B_HI;
        pbps_pkg::REG_SEL_C: next_selC = wrData & pbps_pkg::MASK_C;
        default: ;
      endcase
    end
    if (rdEn) begin
      unique case (addr)
        pbps_pkg::REG_SEL_B_LO: next_rdData = selLo;
        pbps_pkg::REG_SEL_B_HI: next_rdData = selHi;
        pbps_pkg::REG_SEL_C: next_rdData = selC;
        default: next_rdData = 16'h0000;
      endcase
    end
  end

  // register state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selLo <= pbps_pkg::RESET_SEL;
      selHi <= pbps_pkg::RESET_SEL;
      selC <= pbps_pkg::RESET_SEL;
      rdData <= 16'h0000;
    end else begin
      selLo <= next_selLo;
      selHi <= next_selHi;
      selC <= next_selC;
      rdData <= next_rdData;
    end
  end

  // field extraction
  assign b5 = selLo[pbps_pkg::B5_LSB +: 2];
  assign b4 = selLo[pbps_pkg::B4_LSB +: 3];
  assign b3 = selLo[pbps_pkg::B3_LSB +: 3];
  assign b2 = selLo[pbps_pkg::B2_LSB +: 2];
  assign b1 = selLo[pbps_pkg::B1_LSB +: 2];
  assign b0 = selLo[pbps_pkg::B0_LSB +: 3];
  assign b7 = selHi[pbps_pkg::B7_LSB +: 2];
  assign b6 = selHi[pbps_pkg::B6_LSB +: 2];
  assign portCSelect = selC[1:0];
  assign gpioIn = padIn;

  // pad output mux and input select masks
  always_comb begin
    padOut = gpioOut;
    padOeN = gpioOeN;
    padAnalogSel = 8'h00;
    mT0 = 8'h00;
    mT1 = 8'h00;
    mFault3 = 8'h00;
    mSclk = 8'h00;
    mMiso = 8'h00;
    mMosi = 8'h00;
    mSs = 8'h00;
    mSda = 8'h00;
    mScl = 8'h00;
    mRx = 8'h00;
    mTx = 8'h00;
    mTin2 = 8'h00;
    mTin3 = 8'h00;
    mClkIn = 8'h00;
    // peripheral-owned pads start undriven; reserved codes stay that way
    for (int i = 0; i < 8; i++) begin
      if (padPeripheralEnable[i]) begin
        padOut[i] = 1'b0;
        padOeN[i] = 1'b1;
      end
    end
    // pad B5
    if (padPeripheralEnable[5]) begin
      unique case (b5)
        2'h0: begin
          padOut[5] = periphOut.timer1Out;
          padOeN[5] = ~periphOut.timer1Drive;
          mT1[5] = 1'b1;
        end
        2'h1: mFault3[5] = 1'b1;
        2'h2: begin
          padOut[5] = periphOut.spiClkOut;
          padOeN[5] = ~periphOut.spiClkDrive;
          mSclk[5] = 1'b1;
        end
        default: ;
      endcase
    end
    // pad B4
    if (padPeripheralEnable[4]) begin
      unique case (b4)
        3'h0: begin
          padOut[4] = periphOut.timer0Out;
          padOeN[4] = ~periphOut.timer0Drive;
          mT0[4] = 1'b1;
        end
        3'h1: begin
          padOut[4] = periphOut.clockOutputZero;
          padOeN[4] = 1'b0;
        end
        3'h2: begin
          padOut[4] = periphOut.spiMisoOut;
          padOeN[4] = ~periphOut.spiMisoDrive;
          mMiso[4] = 1'b1;
        end
        3'h3: begin
          padOut[4] = periphOut.i2cSdaOut;
          padOeN[4] = ~periphOut.i2cSdaDrive;
          mSda[4] = 1'b1;
        end
        3'h4: mRx[4] = 1'b1;
        3'h5: padAnalogSel[4] = 1'b1;
        default: ;
      endcase
    end
    // pad B3
    if (padPeripheralEnable[3]) begin
      unique case (b3)
        3'h0: begin
          padOut[3] = periphOut.spiMosiOut;
          padOeN[3] = ~periphOut.spiMosiDrive;
          mMosi[3] = 1'b1;
        end
        3'h1: mTin3[3] = 1'b1;
        3'h2: padAnalogSel[3] = 1'b1;
        3'h3: begin
          padOut[3] = periphOut.pulseOutputFive;
          padOeN[3] = 1'b0;
        end
        3'h4: begin
          padOut[3] = periphOut.comparatorOneResult;
          padOeN[3] = 1'b0;
        end
        default: ;
      endcase
    end
    // pad B2
    if (padPeripheralEnable[2]) begin
      unique case (b2)
        2'h0: begin
          padOut[2] = periphOut.spiMisoOut;
          padOeN[2] = ~periphOut.spiMisoDrive;
          mMiso[2] = 1'b1;
        end
        2'h1: mTin2[2] = 1'b1;
        2'h2: padAnalogSel[2] = 1'b1;
        2'h3: begin
          padOut[2] = periphOut.comparatorZeroResult;
          padOeN[2] = 1'b0;
        end
      endcase
    end
    // pad B1
    if (padPeripheralEnable[1]) begin
      unique case (b1)
        2'h0: begin
          padOut[1] = periphOut.spiSlaveSelectOut;
          padOeN[1] = ~periphOut.spiSlaveSelectDrive;
          mSs[1] = 1'b1;
        end
        2'h1: begin
          padOut[1] = periphOut.i2cSdaOut;
          padOeN[1] = ~periphOut.i2cSdaDrive;
          mSda[1] = 1'b1;
        end
        2'h2: padAnalogSel[1] = 1'b1;
        default: ;
      endcase
    end
    // pad B0
    if (padPeripheralEnable[0]) begin
      unique case (b0)
        3'h0: mSclk[0] = 1'b1;
        3'h1: begin
          padOut[0] = periphOut.i2cSclOut;
          padOeN[0] = ~periphOut.i2cSclDrive;
          mScl[0] = 1'b1;
        end
        3'h2: padAnalogSel[0] = 1'b1;
        3'h3: begin
          padOut[0] = periphOut.pulseOutputThree;
          padOeN[0] = 1'b0;
        end
        3'h4: begin
          padOut[0] = periphOut.timer1Out;
          padOeN[0] = ~periphOut.timer1Drive;
          mT1[0] = 1'b1;
        end
        default: ;
      endcase
    end
    // pad B7
    if (padPeripheralEnable[7]) begin
      unique case (b7)
        2'h0: begin
          padOut[7] = periphOut.sciTxOut;
          padOeN[7] = ~periphOut.sciTxDrive;
          mTx[7] = 1'b1;
        end
        2'h1: begin
          padOut[7] = periphOut.i2cSclOut;
          padOeN[7] = ~periphOut.i2cSclDrive;
          mScl[7] = 1'b1;
        end
        2'h2: padAnalogSel[7] = 1'b1;
        default: ;
      endcase
    end
    // pad B6
    if (padPeripheralEnable[6]) begin
      unique case (b6)
        2'h0: mRx[6] = 1'b1;
        2'h1: begin
          padOut[6] = periphOut.i2cSdaOut;
          padOeN[6] = ~periphOut.i2cSdaDrive;
          mSda[6] = 1'b1;
        end
        2'h2: padAnalogSel[6] = 1'b1;
        2'h3: mClkIn[6] = 1'b1;
      endcase
    end
  end

  // peripheral inputs gathered from the selected pads
  always_comb begin
    periphIn.timer0In = joinIn(mT0, padIn, pbps_pkg::IDLE_LOW);
    periphIn.timer1In = joinIn(mT1, padIn, pbps_pkg::IDLE_LOW);
    periphIn.faultInputThree = joinIn(mFault3, padIn, pbps_pkg::IDLE_LOW);
    periphIn.spiClkIn = joinIn(mSclk, padIn, pbps_pkg::IDLE_LOW);
    periphIn.spiMisoIn = joinIn(mMiso, padIn, pbps_pkg::IDLE_LOW);
    periphIn.spiMosiIn = joinIn(mMosi, padIn, pbps_pkg::IDLE_LOW);
    periphIn.spiSlaveSelectIn = joinIn(mSs, padIn, pbps_pkg::IDLE_HIGH);
    periphIn.i2cSdaIn = joinIn(mSda, padIn, pbps_pkg::IDLE_HIGH);
    periphIn.i2cSclIn = joinIn(mScl, padIn, pbps_pkg::IDLE_HIGH);
    periphIn.sciRxIn = joinIn(mRx, padIn, pbps_pkg::IDLE_HIGH);
    periphIn.sciTxIn = joinIn(mTx, padIn, pbps_pkg::IDLE_HIGH);
    periphIn.timerInputTwo = joinIn(mTin2, padIn, pbps_pkg::IDLE_LOW);
    periphIn.timerInputThree = joinIn(mTin3, padIn, pbps_pkg::IDLE_LOW);
    periphIn.externalClockInput = joinIn(mClkIn, padIn, pbps_pkg::IDLE_LOW);
  end

endmodule : pbps_pin_mux

/* tb/pbps_pin_mux_chk.sv */
module pbps_pin_mux_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [15:0] rdData,
  // pads and peripherals
  input wire logic [7:0] padPeripheralEnable,
  input wire logic [7:0] gpioOut,
  input wire logic [7:0] gpioOeN,
  input wire logic [7:0] padIn,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOeN,
  input wire pbps_pkg::pbps_periph_out_t periphOut,
  input wire pbps_pkg::pbps_periph_in_t periphIn,
  input wire logic [1:0] portCSelect
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hiSel;
  logic [3:0] next_hiSel;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // shadow of the upper select fields
  always_comb begin
    next_hiSel = hiSel;
    if (wrEn && addr == 8'h0D) begin
      next_hiSel = wrData[3:0];
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hiSel <= 4'h0;
    end else begin
      hiSel <= next_hiSel;
    end
  end

  // register reads and the port C field output
  property p_lo_resv; $past(rdEn) && $past(addr) == 8'h0C |-> !rdData[5]; endproperty
  a_lo_resv: assert property (p_lo_resv) else $error("reserved bit 5 read set");
  property p_unmap; $past(rdEn) && $past(addr) > 8'h0E |-> rdData == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_wrrd;
    wrEn && addr == 8'h0D ##1 rdEn && addr == 8'h0D |=> rdData == {12'h000, $past(wrData[3:0], 2)};
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("upper select readback wrong");
  property p_portc; wrEn && addr == 8'h0E |=> portCSelect == $past(wrData[1:0]); endproperty
  a_portc: assert property (p_portc) else $error("port C field not stored");
  // pad ownership and muxing
  property p_gpio;
    padPeripheralEnable != 8'hFF |->
      (((padOut ^ gpioOut) | (padOeN ^ gpioOeN)) & ~padPeripheralEnable) == 8'h00;
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio pad not passed through");
  property p_b6clk;
    padPeripheralEnable[6] && hiSel[1:0] == 2'b11 |-> periphIn.externalClockInput == padIn[6];
  endproperty
  a_b6clk: assert property (p_b6clk) else $error("clock input not fed from pad 6");
  property p_b7tx;
    padPeripheralEnable[7] && hiSel[3:2] == 2'b00 |->
      padOut[7] == periphOut.sciTxOut && padOeN[7] == !periphOut.sciTxDrive;
  endproperty
  a_b7tx: assert property (p_b7tx) else $error("pad 7 not serial transmit");
  property p_b7resv;
    padPeripheralEnable[7] && hiSel[3:2] == 2'b11 |-> padOeN[7] && !padOut[7];
  endproperty
  a_b7resv: assert property (p_b7resv) else $error("reserved code drives pad 7");
endmodule : pbps_pin_mux_chk

bind pbps_pin_mux pbps_pin_mux_chk pbps_pin_mux_chk_inst (.clk, .rstn, .addr, .wrData, .wrEn,
  .rdEn, .rdData, .padPeripheralEnable, .gpioOut, .gpioOeN, .padIn, .padOut, .padOeN,
  .periphOut, .periphIn, .portCSelect);

/* tb/pbps_periph_model.sv */
module pbps_periph_model (
  // pad side
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOeN,
  input wire logic [7:0] ext,
  output logic [7:0] padIn,
  // peripheral side
  input wire pbps_pkg::pbps_periph_out_t drv,
  output pbps_pkg::pbps_periph_out_t periphOut
);
  timeunit 1ns;
  timeprecision 1ns;
  // pad level: own drive when enabled, else the outside world
  assign padIn = (padOut & ~padOeN) | (ext & padOeN);
  // peripheral outputs as commanded by the bench
  assign periphOut = drv;
endmodule : pbps_periph_model

/* tb/pbps_pin_mux_tb_top.sv */
module pbps_pin_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rstn;
  logic [7:0] addr;
  logic [15:0] wrData;
  logic wrEn;
  logic rdEn;
  logic [15:0] rdData;
  logic [7:0] padPeripheralEnable;
  logic [7:0] gpioOut;
  logic [7:0] gpioOeN;
  logic [7:0] gpioIn;
  logic [7:0] padIn;
  logic [7:0] padOut;
  logic [7:0] padOeN;
  logic [7:0] padAnalogSel;
  logic [7:0] ext;
  logic [1:0] portCSelect;
  pbps_pkg::pbps_periph_out_t drv;
  pbps_pkg::pbps_periph_out_t periphOut;
  pbps_pkg::pbps_periph_in_t periphIn;
  int numErrors = 0;
  int nChecks = 0;

  pbps_pin_mux pbps_pin_mux_inst (.clk, .rstn, .addr, .wrData, .wrEn, .rdEn, .rdData,
    .padPeripheralEnable, .gpioOut, .gpioOeN, .gpioIn, .padIn, .padOut, .padOeN,
    .padAnalogSel, .periphOut, .periphIn, .portCSelect);
  pbps_periph_model pbps_periph_model_inst (.padOut, .padOeN, .ext, .padIn, .drv, .periphOut);

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one bus cycle, driven right after an edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    wrEn <= w;
    rdEn <= r;
    addr <= a;
    wrData <= d;
    @(posedge clk);
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, a, d);
    wrEn <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    acc(1'b0, 1'b1, a, 16'h0000);
    rdEn <= 1'b0;
    #1;
    chk("rdData", exp, rdData);
    @(posedge clk);
  endtask : rd

  // peripherals quiet while fields change
  task automatic pads(input logic [15:0] lo, input logic [15:0] hi);
    drv <= '0;
    wr(8'h0C, lo);
    wr(8'h0D, hi);
    #1;
  endtask : pads

  task automatic tRegs;
    rd(8'h0C, 16'h0000);
    rd(8'h0D, 16'h0000);
    wr(8'h0C, 16'hFFFF);
    rd(8'h0C, 16'hFFDF);
    acc(1'b1, 1'b0, 8'h0D, 16'hFFFF);
    rd(8'h0D, 16'h000F);
    wr(8'h0E, 16'hFFFF);
    chk("portCSelect", 16'h0003, {14'h0000, portCSelect});
    rd(8'h0E, 16'h0003);
    wr(8'h3F, 16'hFFFF);
    rd(8'h3F, 16'h0000);
    $display("registers test done");
  endtask : tRegs

  task automatic tGpio;
    padPeripheralEnable <= 8'h00;
    #1;
    chk("padOut", {8'h00, gpioOut}, {8'h00, padOut});
    chk("padOeN", {8'h00, gpioOeN}, {8'h00, padOeN});
    chk("gpioIn", 16'h0081, {8'h00, gpioIn});
    @(posedge clk);
    padPeripheralEnable <= 8'hFF;
    $display("gpio test done");
  endtask : tGpio

  task automatic tAnalog;
    pads(16'h2A92, 16'h000A);
    chk("padAnalogSel", 16'h00DF, {8'h00, padAnalogSel});
    chk("padOeN", 16'h00DF, {8'h00, padOeN & 8'hDF});
    chk("sda idle", 16'h0001, {15'h0000, periphIn.i2cSdaIn});
    chk("timer_input_two idle", 16'h0000, {15'h0000, periphIn.timerInputTwo});
    @(posedge clk);
    $display("analog test done");
  endtask : tAnalog

  task automatic tOutputs;
    pads(16'h0BC3, 16'h0003);
    @(posedge clk);
    drv <= '1;
    #1;
    chk("padOut", 16'h00BF, {8'h00, padOut});
    chk("padOeN", 16'h0040, {8'h00, padOeN});
    @(posedge clk);
    drv <= '0;
    ext <= 8'h40;
    #1;
    chk("padOeN", 16'h00E2, {8'h00, padOeN});
    chk("clock in", 16'h0001, {15'h0000, periphIn.externalClockInput});
    chk("periphIn", 16'h0071, {2'b00, periphIn});
    @(posedge clk);
    ext <= 8'h00;
    $display("outputs test done");
  endtask : tOutputs

  task automatic tShare;
    pads(16'h9808, 16'h0000);
    @(posedge clk);
    ext <= 8'h11;
    #1;
    chk("sda", 16'h0000, {15'h0000, periphIn.i2cSdaIn});
    chk("spi clk", 16'h0001, {15'h0000, periphIn.spiClkIn});
    chk("periphIn", 16'h04A0, {2'b00, periphIn});
    @(posedge clk);
    ext <= 8'h12;
    #1;
    chk("sda", 16'h0001, {15'h0000, periphIn.i2cSdaIn});
    chk("spi clk", 16'h0000, {15'h0000, periphIn.spiClkIn});
    @(posedge clk);
    drv <= '1;
    #1;
    chk("padOeN", 16'h0001, {8'h00, padOeN & 8'h21});
    @(posedge clk);
    ext <= 8'h00;
    $display("shared pads test done");
  endtask : tShare

  // input-only and remaining codes, shared serial receive
  task automatic tInputs;
    pads(16'h4144, 16'h0005);
    @(posedge clk);
    ext <= 8'h3C;
    #1;
    chk("periphIn", 16'h281E, {2'b00, periphIn});
    @(posedge clk);
    ext <= 8'hC3;
    #1;
    chk("periphIn", 16'h10F8, {2'b00, periphIn});
    @(posedge clk);
    drv <= '1;
    ext <= 8'h00;
    #1;
    chk("padOut", 16'h00D3, {8'h00, padOut});
    chk("padOeN", 16'h002C, {8'h00, padOeN});
    @(posedge clk);
    pads(16'h2001, 16'h0000);
    @(posedge clk);
    ext <= 8'h11;
    #1;
    chk("periphIn", 16'h0060, {2'b00, periphIn});
    @(posedge clk);
    ext <= 8'h51;
    #1;
    chk("periphIn", 16'h0070, {2'b00, periphIn});
    @(posedge clk);
    ext <= 8'h00;
    $display("inputs test done");
  endtask : tInputs

  task automatic tResv;
    pads(16'hFFFF, 16'h000C);
    @(posedge clk);
    drv <= '1;
    #1;
    chk("padOut", 16'h0004, {8'h00, padOut});
    chk("padOeN", 16'h00FB, {8'h00, padOeN});
    chk("periphIn", 16'h00E8, {2'b00, periphIn});
    @(posedge clk);
    $display("reserved codes test done");
  endtask : tResv

  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finishTest

  // main sequence
  initial begin
    rstn = 1'b0;
    addr = 8'h00;
    wrData = 16'h0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
    padPeripheralEnable = 8'hFF;
    gpioOut = 8'hA5;
    gpioOeN = 8'h3C;
    ext = 8'h00;
    drv = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    tRegs();
    tGpio();
    tAnalog();
    tOutputs();
    tShare();
    tInputs();
    tResv();
    finishTest();
  end

  // hang guard
  initial begin
    #500000;
    numErrors++;
    finishTest();
  end
endmodule : pbps_pin_mux_tb_top
